// ### shared/tight_memory_cfg.svh
// Constants for the tight memory SRAM port.
// Assumes inclusion by bare name from design files.
`ifndef TIGHT_MEMORY_CFG_SVH
`define TIGHT_MEMORY_CFG_SVH
`define TM_DATA_W      64
`define TM_ADDR_W      20
`define TM_LANES       8
`define TM_CS_W        2
`define TM_LANES_PER_CS 4
`define TM_DMA_GAP_CYC 2
`endif

// ### shared/tight_memory_pkg.sv
// Types for the tight memory SRAM port.
// Assumes no surroundings beyond the cfg header.
package tight_memory_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WAIT = 3'b010,
      ST_DMA  = 3'b100
   } own_state_e;
endpackage

// ### core/byte_parity_gen.sv
// Odd parity generator, one bit per byte lane.
// Assumes combinational use; the caller registers the result.
`timescale 1ns/1ps
`include "tight_memory_cfg.svh"
module byte_parity_gen
(
   input  wire logic [`TM_DATA_W-1:0] data,
   output logic      [`TM_LANES-1:0]  parity
);
   // One when the byte holds an even count of ones
   function automatic logic odd_bit(input logic [7:0] b);
      odd_bit = ~(^b);
   endfunction

   genvar g;
   generate
      for (g = 0; g < `TM_LANES; g = g + 1)
      begin : lane
         assign parity[g] = odd_bit(data[8*g +: 8]); // RULE9
      end
   endgenerate
endmodule

// ### core/tight_memory_sram_port.sv
// Processor-side port to one tightly coupled SRAM bank pair.
// Assumes SRAM and DMA share clk; mem_wait_in is synchronous to clk.
`timescale 1ns/1ps
`include "tight_memory_cfg.svh"
// Summary of operation
// RULE1: All RAM outputs zero during reset
// RULE2: Memory returns read data next cycle
// RULE3: Waited read data follows wait release
// RULE4: Any wait length extends the access
// RULE5: Write data launched with address, control
// RULE6: Write incomplete until wait released
// RULE7: DMA ownership forces outputs to zero
// RULE8: DMA request low two cycles between
// RULE9: Odd parity per byte lane
// RULE10: Parity always on, not configurable
// RULE11: No parity check on read data
// RULE12: Instruction parity bit n covers byte n
// RULE13: Data parity bit n covers byte n
// RULE14: Wait ignored without a request presented
// RULE15: Chip select per half, enable per lane
// RULE16: DMA requests a cycle before use
// RULE17: Processor wins; DMA after pending work
// RULE18: Parity launched with its data byte
module tight_memory_sram_port
   import tight_memory_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   rst_b,
   input  wire logic                   cpu_req,
   input  wire logic                   cpu_write,
   input  wire logic [`TM_ADDR_W-1:0]  cpu_addr,
   input  wire logic [`TM_LANES-1:0]   cpu_byte_en,
   input  wire logic [`TM_DATA_W-1:0]  cpu_wdata,
   input  wire logic                   pend_writes,
   output logic                        cpu_ready,
   output logic                        cpu_rvalid,
   output logic [`TM_DATA_W-1:0]       cpu_rdata,
   output logic                        dma_granted,
   input  wire logic                   dma_port_request,
   input  wire logic                   mem_wait_in,
   input  wire logic [`TM_DATA_W-1:0]  ram_read_data,
   output logic [`TM_CS_W-1:0]         ram_chip_select,
   output logic                        ram_write_en,
   output logic [`TM_ADDR_W-1:0]       ram_addr,
   output logic [`TM_LANES-1:0]        byte_write_lane_enable,
   output logic [`TM_DATA_W-1:0]       ram_write_data,
   output logic [`TM_LANES-1:0]        ram_write_parity
);
   own_state_e                 state_reg, state_next;
   logic [`TM_CS_W-1:0]        cs_reg;
   logic                       we_reg;
   logic [`TM_ADDR_W-1:0]      addr_reg;
   logic [`TM_LANES-1:0]       bwe_reg;
   logic [`TM_DATA_W-1:0]      wd_reg;
   logic [`TM_LANES-1:0]       par_reg;
   logic                       rd_pend_reg;
   logic [`TM_DATA_W-1:0]      rdata_reg;
   logic                       rvalid_reg;
   logic [`TM_LANES-1:0]       par_next;

   // Chip select for a lane group: any byte enabled in that half
   function automatic logic [`TM_CS_W-1:0] cs_of(
      input logic [`TM_LANES-1:0] be);
      cs_of = {|be[7:4], |be[3:0]};
   endfunction

   wire active     = |cs_reg;
   wire wait_seen  = active && mem_wait_in;      // RULE14
   wire in_dma     = (state_reg == ST_DMA);
   wire can_issue  = !in_dma && !wait_seen;
   wire take_cpu   = cpu_req && can_issue;        // RULE17
   wire dma_ok     = dma_port_request && !cpu_req && !pend_writes
                     && !wait_seen;               // RULE17
   wire rd_done    = rd_pend_reg && !wait_seen;   // RULE3 RULE14

   byte_parity_gen u_par
   (
      .data   (cpu_wdata),
      .parity (par_next)
   );

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:
            if (wait_seen)
               state_next = ST_WAIT;
            else if (dma_ok)
               state_next = ST_DMA;
         ST_WAIT:
            if (!mem_wait_in)
               state_next = ST_IDLE;              // RULE6
         ST_DMA:
            if (!dma_port_request)
               state_next = ST_IDLE;              // RULE16
         default:
            state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
         state_reg <= ST_IDLE;
      else
         state_reg <= state_next;
   end

   // Launch address, control, data and parity together
   always_ff @(posedge clk)
   begin
      if (!rst_b || state_next == ST_DMA)
      begin
         cs_reg   <= '0;                          // RULE1 RULE7
         we_reg   <= 1'b0;
         addr_reg <= '0;
         bwe_reg  <= '0;
         wd_reg   <= '0;
         par_reg  <= '0;
      end
      else if (!wait_seen)                        // RULE4
      begin
         cs_reg   <= take_cpu ? cs_of(cpu_byte_en) : '0; // RULE15
         we_reg   <= take_cpu && cpu_write;
         addr_reg <= take_cpu ? cpu_addr : '0;
         bwe_reg  <= (take_cpu && cpu_write) ? cpu_byte_en : '0;
         wd_reg   <= (take_cpu && cpu_write) ? cpu_wdata : '0; // RULE5
         par_reg  <= (take_cpu && cpu_write) ? par_next : '0;  // RULE18
      end
   end

   // Read return; parity of read data is never checked
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         rd_pend_reg <= 1'b0;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= '0;
      end
      else
      begin
         rvalid_reg <= rd_done;                   // RULE2 RULE11
         if (rd_done)
            rdata_reg <= ram_read_data;
         if (!wait_seen)
            rd_pend_reg <= take_cpu && !cpu_write;
      end
   end

   assign cpu_ready              = can_issue;
   assign cpu_rvalid             = rvalid_reg;
   assign cpu_rdata              = rdata_reg;
   assign dma_granted            = in_dma;
   assign ram_chip_select        = cs_reg;
   assign ram_write_en           = we_reg;
   assign ram_addr               = addr_reg;
   assign byte_write_lane_enable = bwe_reg;
   assign ram_write_data         = wd_reg;
   assign ram_write_parity       = par_reg;   // RULE10 RULE12 RULE13

   logic [1:0] dma_low_cnt_reg;
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         dma_low_cnt_reg <= 2'(`TM_DMA_GAP_CYC);
      else if (dma_port_request)
         dma_low_cnt_reg <= 2'h0;
      else if (dma_low_cnt_reg != 2'(`TM_DMA_GAP_CYC))
         dma_low_cnt_reg <= dma_low_cnt_reg + 2'h1;
   end

   AST_RESET_ZERO: assert property (@(posedge clk) // RULE1
      !rst_b |=> ({ram_chip_select, ram_write_en, ram_addr,
                   byte_write_lane_enable, ram_write_data,
                   ram_write_parity} == '0))
      else $error("RAM outputs not zero after reset");
   AST_DMA_ZERO: assert property (@(posedge clk) disable iff (!rst_b) // RULE7
      in_dma |-> ({ram_chip_select, ram_write_en, ram_addr,
                   byte_write_lane_enable, ram_write_data,
                   ram_write_parity} == '0))
      else $error("RAM outputs driven during DMA");
   AST_WAIT_HOLD: assert property (@(posedge clk) disable iff (!rst_b) // RULE4
      wait_seen |=> $stable(ram_addr) && $stable(ram_chip_select))
      else $error("Access not held during wait");
   AST_WAIT_STATE: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
      (state_reg == ST_IDLE && wait_seen) |=> state_reg == ST_WAIT)
      else $error("Wait not recorded");
   AST_NO_WAIT_IDLE: assert property (@(posedge clk) // RULE14
      disable iff (!rst_b)
      (!active && mem_wait_in && state_reg == ST_IDLE && !dma_ok)
      |=> state_reg == ST_IDLE)
      else $error("Wait acted on without request");
   AST_WDATA_WITH_ADDR: assert property (@(posedge clk) // RULE5
      disable iff (!rst_b)
      (take_cpu && cpu_write && !wait_seen && !dma_ok)
      |=> ram_write_en && ram_write_data == $past(cpu_wdata))
      else $error("Write data not launched with address");
   AST_PARITY_ODD: assert property (@(posedge clk) disable iff (!rst_b) // RULE9
      ram_write_en |-> (^{ram_write_data[7:0], ram_write_parity[0]})
      && (^{ram_write_data[63:56], ram_write_parity[7]}))
      else $error("Parity not odd");
   AST_RDATA_NEXT: assert property (@(posedge clk) disable iff (!rst_b) // RULE2
      (rd_pend_reg && !mem_wait_in) |=> cpu_rvalid
      && cpu_rdata == $past(ram_read_data))
      else $error("Read data not captured");
   AST_CPU_PRIO: assert property (@(posedge clk) disable iff (!rst_b) // RULE17
      (state_reg == ST_IDLE && cpu_req && dma_port_request)
      |=> !in_dma)
      else $error("DMA won over processor");
   AST_CS_LANES: assert property (@(posedge clk) disable iff (!rst_b) // RULE15
      ram_write_en |-> ram_chip_select ==
      {|byte_write_lane_enable[7:4], |byte_write_lane_enable[3:0]})
      else $error("Chip select lane mismatch");

   COV_READ_WAIT: cover property (@(posedge clk) disable iff (!rst_b)
      rd_pend_reg && mem_wait_in ##1 !mem_wait_in ##1 cpu_rvalid);
   COV_WRITE_WAIT: cover property (@(posedge clk) disable iff (!rst_b)
      ram_write_en && mem_wait_in ##1 mem_wait_in);
   COV_DMA: cover property (@(posedge clk) disable iff (!rst_b)
      state_reg == ST_IDLE ##1 in_dma ##1 state_reg == ST_IDLE);
   COV_DMA_GAP: cover property (@(posedge clk) disable iff (!rst_b)
      dma_low_cnt_reg == 2'(`TM_DMA_GAP_CYC) && dma_port_request);
endmodule

// ### bench/sram_bank_model.sv
// Behavioural SRAM bank pair, falling-edge, with a set wait count.
// Assumes the port's clk; the bench sets wait_cycles while idle.
`timescale 1ns/1ps
`include "tight_memory_cfg.svh"
module sram_bank_model
(
   input  wire logic                  clk,
   input  wire logic [7:0]            wait_cycles,
   input  wire logic [`TM_CS_W-1:0]   ram_chip_select,
   input  wire logic                  ram_write_en,
   input  wire logic [`TM_ADDR_W-1:0] ram_addr,
   input  wire logic [`TM_LANES-1:0]  byte_write_lane_enable,
   input  wire logic [`TM_DATA_W-1:0] ram_write_data,
   output logic                       mem_wait_in,
   output logic [`TM_DATA_W-1:0]      ram_read_data
);
   logic [`TM_DATA_W-1:0] mem [16];
   logic [7:0]            left_reg = 8'h00;
   wire                   sel = |ram_chip_select;
   initial ram_read_data = '0;
   // Wait may also stand while deselected; the port must ignore it
   assign mem_wait_in = left_reg != 8'h00;
   always @(posedge clk)
      if (!sel || left_reg == 8'h00)
         left_reg <= wait_cycles;
      else
         left_reg <= left_reg - 8'h01;
   // Data valid only in the non-waited cycle; otherwise it toggles
   always @(negedge clk)
      if (sel && !mem_wait_in)
      begin
         for (int i = 0; i < `TM_LANES; i++)
            if (ram_write_en && byte_write_lane_enable[i])
               mem[ram_addr[3:0]][8*i +: 8] <= ram_write_data[8*i +: 8];
         ram_read_data <= mem[ram_addr[3:0]];
      end
      else
         ram_read_data <= ~ram_read_data;
endmodule

// ### bench/tight_memory_sram_port_bench.sv
// Self-checking bench for the tight memory SRAM port.
// Assumes sram_bank_model on the memory side; the bench acts as DMA.
`timescale 1ns/1ps
`include "tight_memory_cfg.svh"
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin fails++; \
   $display("[ERR] %s exp %h got %h", nm, e, s); end end
module tight_memory_sram_port_bench
   import tight_memory_pkg::*;
();
   typedef struct {logic w; logic [3:0] a; logic [7:0] be;
      logic [63:0] d; logic [7:0] nw;} row_s;
   logic                  clk = 0, rst_b = 0, cpu_req = 0, cpu_write = 0;
   logic                  pend_writes = 0, dma_port_request = 0;
   logic [`TM_ADDR_W-1:0] cpu_addr = '0, ram_addr;
   logic [`TM_LANES-1:0]  cpu_byte_en = '0, byte_write_lane_enable;
   logic [`TM_LANES-1:0]  ram_write_parity;
   logic [`TM_DATA_W-1:0] cpu_wdata = '0, cpu_rdata, ram_read_data;
   logic [`TM_DATA_W-1:0] ram_write_data, shadow [16];
   logic [`TM_CS_W-1:0]   ram_chip_select;
   logic                  cpu_ready, cpu_rvalid, dma_granted;
   logic                  ram_write_en, mem_wait_in;
   logic [7:0]            wait_cycles = 8'h00;
   int                    fails = 0, tests_run = 0, cycles = 0;
   wire [102:0] ram_outs = {ram_chip_select, ram_write_en, ram_addr,
      byte_write_lane_enable, ram_write_data, ram_write_parity};
   row_s rows [6] = '{
      '{1'h1, 4'h1, 8'hff, 64'h0123456789abcdef, 8'h00},
      '{1'h1, 4'h2, 8'hff, 64'h00ff00ff00000001, 8'h02},
      '{1'h0, 4'h1, 8'hff, 64'h0, 8'h00},
      '{1'h0, 4'h2, 8'hff, 64'h0, 8'h04},
      '{1'h1, 4'h1, 8'hf0, 64'ha5a5a5a55a5a5a5a, 8'h01},
      '{1'h0, 4'h1, 8'h0f, 64'h0, 8'h01}};
   always #5 clk = ~clk;
   tight_memory_sram_port u_dut (.clk, .rst_b, .cpu_req, .cpu_write,
      .cpu_addr, .cpu_byte_en, .cpu_wdata, .pend_writes, .cpu_ready,
      .cpu_rvalid, .cpu_rdata, .dma_granted, .dma_port_request,
      .mem_wait_in, .ram_read_data, .ram_chip_select, .ram_write_en,
      .ram_addr, .byte_write_lane_enable, .ram_write_data,
      .ram_write_parity);
   sram_bank_model u_mem (.clk, .wait_cycles, .ram_chip_select,
      .ram_write_en, .ram_addr, .byte_write_lane_enable, .ram_write_data,
      .mem_wait_in, .ram_read_data);
   function automatic logic [7:0] par(input logic [63:0] d);
      for (int i = 0; i < 8; i++)
         par[i] = ~^d[8*i +: 8];
   endfunction
   task automatic summarize;
      if (fails == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic access(input row_s r);
      int           n;
      logic [21:0]  req_e;
      logic [100:0] wr_e;
      cpu_write = r.w;
      cpu_addr = {16'h0c3a, r.a};
      cpu_byte_en = r.be;
      cpu_wdata = r.d;
      wait_cycles = r.nw;
      cpu_req = 1'h1;
      n = 0;
      while (cpu_ready !== 1'h1 && n < 40)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      @(posedge clk);
      #1;
      cpu_req = 1'h0;
      n = 0;
      req_e = {|r.be[7:4], |r.be[3:0], cpu_addr};
      `CHK("req", req_e, {ram_chip_select, ram_addr})
      if (r.w)
      begin
         wr_e = {1'h1, cpu_addr, r.be, r.d, par(r.d)};
         `CHK("wr", wr_e, ram_outs[100:0])
         for (int i = 0; i < 8; i++)
            if (r.be[i])
               shadow[r.a][8*i +: 8] = r.d[8*i +: 8];
      end
      while (mem_wait_in === 1'h1 && n < 40)
      begin
         `CHK("ready", 1'h0, cpu_ready)
         @(posedge clk);
         #1;
         n++;
      end
      `CHK("waits", r.nw, n[7:0])
      @(posedge clk);
      #1;
      if (!r.w)
      begin
         `CHK("rvalid", 1'h1, cpu_rvalid)
         `CHK("rdata", shadow[r.a], cpu_rdata)
      end
   endtask
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         fails++;
         summarize();
      end
   end
   initial
   begin
      cpu_req = 1'h1;
      cpu_write = 1'h1;
      cpu_wdata = 64'hffffffffffffffff;
      repeat (10) @(posedge clk);
      #1;
      `CHK("rst", 103'h0, ram_outs)
      rst_b = 1'h1;
      cpu_req = 1'h0;
      foreach (rows[i])
         access(rows[i]);
      // Queued writes hold the DMA engine off
      pend_writes = 1'h1;
      dma_port_request = 1'h1;
      repeat (3) @(posedge clk);
      #1;
      `CHK("hold", 1'h0, dma_granted)
      pend_writes = 1'h0;
      repeat (2) @(posedge clk);
      #1;
      cpu_req = 1'h1;
      `CHK("grant", 1'h1, dma_granted)
      `CHK("zero", 103'h0, ram_outs)
      `CHK("busy", 1'h0, cpu_ready)
      cpu_req = 1'h0;
      dma_port_request = 1'h0;
      repeat (3) @(posedge clk);
      #1;
      // Same-cycle contention: processor goes first
      dma_port_request = 1'h1;
      access(rows[0]);
      repeat (2) @(posedge clk);
      #1;
      `CHK("late", 1'h1, dma_granted)
      dma_port_request = 1'h0;
      summarize();
   end
endmodule
